// ===== core/adcs_input_regs.sv
// Behaviour
// - Scan off uses low select only; single ended scan uses union of high and low.
// - Single ended codes 0 to 14 connect analog pins 0 to 14.
// - Code 15 routes amplifier 0 output, code 16 amplifier 1 output.
// - Code 17 half supply reference, 18 bandgap; other codes reserved.
// - Differential single: bit 0 ignored, n selects pins 2n and 2n+1.
// - Scan single ended: low bit n adds pin n to scan set.
// - Scan differential: low bit n adds pair 2n, 2n+1; bits 6-7 zero.
// - In scan, selection read returns channel of current result.
// - Offset register is 8 bits, read write, resets to zero.
// - Scan single ended: high bits 0-4 add pins 8-12, 5-6 amplifiers.
// - Reading result high latches result low and scan channel identity.
// - Offset is two's complement, written by calibration, corrects results.
//
// Our own choice: the AHB-Lite slave port.
`timescale 1ns/100ps
module adcs_input_regs (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic conv_done,
    input wire logic [13:0] conv_raw,
    input wire logic cal_done,
    input wire logic [7:0] cal_value,
    output adcs_pkg::adcs_mux_t mux_sel,
    output logic [7:0] offset_value,
    output logic scan_mode
);

    ////////////////////////////////////////////////////////////////////////
    // Bus address phase

    logic [11:0] addr_idx;
    logic addr_ok;
    logic access;
    logic rd_acc;
    logic wr_acc;

    assign addr_idx = haddr[adcs_pkg::IDX_MSB:adcs_pkg::IDX_LSB];
    assign addr_ok = haddr[31:adcs_pkg::IDX_MSB + 1] ==
        adcs_pkg::ADDR_HIGH_ZERO;
    assign access = hsel && hready && (htrans == adcs_pkg::HTRANS_NONSEQ);
    assign rd_acc = access && !hwrite;
    assign wr_acc = access && hwrite && addr_ok;

    logic wr_pend_q;
    logic [11:0] wr_idx_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_idx_q <= adcs_pkg::IDX_CTRL;
        end else begin
            wr_pend_q <= wr_acc;
            if (wr_acc) begin
                wr_idx_q <= addr_idx;
            end
        end
    end

    // Zero wait states, always OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= adcs_pkg::HRESP_OKAY;
        end else begin
            hreadyout <= 1'b1;
            hresp <= adcs_pkg::HRESP_OKAY;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Software registers, next values include the pending write

    logic wr_ctrl;
    logic wr_low;
    logic wr_high;
    logic wr_off;

    assign wr_ctrl = wr_pend_q && (wr_idx_q == adcs_pkg::IDX_CTRL);
    assign wr_low = wr_pend_q && (wr_idx_q == adcs_pkg::IDX_SEL_LOW);
    assign wr_high = wr_pend_q && (wr_idx_q == adcs_pkg::IDX_SEL_HIGH);
    assign wr_off = wr_pend_q && (wr_idx_q == adcs_pkg::IDX_OFFSET);

    logic scan_q;
    logic scan_d;
    logic pair_q;
    logic pair_d;
    logic [7:0] sel_low_q;
    logic [7:0] sel_low_d;
    logic [6:0] sel_high_q;
    logic [6:0] sel_high_d;
    logic [7:0] off_q;
    logic [7:0] off_d;

    always_comb begin
        scan_d = scan_q;
        pair_d = pair_q;
        if (wr_ctrl) begin
            scan_d = hwdata[adcs_pkg::CTRL_SCAN_BIT];
            pair_d = hwdata[adcs_pkg::CTRL_PAIR_BIT];
        end
        sel_low_d = wr_low ? hwdata[7:0] : sel_low_q;
        // Top bit reserved, reads zero
        sel_high_d = wr_high ? hwdata[6:0] : sel_high_q;
        // Calibration result wins over a software write
        if (cal_done) begin
            off_d = cal_value;
        end else if (wr_off) begin
            off_d = hwdata[7:0];
        end else begin
            off_d = off_q;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            scan_q <= 1'b0;
            pair_q <= 1'b0;
            sel_low_q <= adcs_pkg::RST_BYTE;
            sel_high_q <= adcs_pkg::RST_HIGH;
        end else begin
            scan_q <= scan_d;
            pair_q <= pair_d;
            sel_low_q <= sel_low_d;
            sel_high_q <= sel_high_d;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            off_q <= adcs_pkg::RST_BYTE;
        end else begin
            off_q <= off_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Scan set and sequencer

    logic [14:0] scan_set;
    logic [3:0] ptr_q;
    logic [3:0] ptr_next;

    // Differential scan takes only the six pair bits
    always_comb begin
        if (pair_q) begin
            scan_set = {9'h000, sel_low_q[adcs_pkg::NUM_PAIRS - 1:0]};
        end else begin
            scan_set = {sel_high_q, sel_low_q};
        end
    end

    adcs_scan_next u_next (
        .set_vec(scan_set),
        .cur(ptr_q),
        .nxt(ptr_next)
    );

    // Skip off unselected inputs, step after each conversion
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ptr_q <= adcs_pkg::CH_FIRST;
        end else if (scan_q && (conv_done || !scan_set[ptr_q])) begin
            ptr_q <= ptr_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Source selection toward the front end

    adcs_pkg::adcs_mux_t mux_d;

    always_comb begin
        mux_d = adcs_pkg::MUX_RESET;
        if (scan_q) begin
            if (pair_q) begin
                mux_d.diff = 1'b1;
                mux_d.pos = {ptr_q, 1'b0};
                mux_d.neg = {ptr_q[2:0], 1'b1};
            end else if (ptr_q == adcs_pkg::CH_AMP0) begin
                mux_d.pos = adcs_pkg::CODE_AMP0;
            end else if (ptr_q == adcs_pkg::CH_AMP1) begin
                mux_d.pos = adcs_pkg::CODE_AMP1;
            end else begin
                mux_d.pos = {1'b0, ptr_q};
            end
        end else if (pair_q) begin
            // Bit 0 plays no part
            mux_d.diff = 1'b1;
            mux_d.pos = {sel_low_q[4:1], 1'b0};
            mux_d.neg = {sel_low_q[3:1], 1'b1};
        end else begin
            // Codes pass straight to the front end decoder
            mux_d.pos = sel_low_q[4:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mux_sel <= adcs_pkg::MUX_RESET;
            scan_mode <= 1'b0;
            offset_value <= adcs_pkg::RST_BYTE;
        end else begin
            mux_sel <= mux_d;
            scan_mode <= scan_q;
            offset_value <= off_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Result capture with offset correction

    logic [13:0] off_ext;
    logic [13:0] comp;
    logic [13:0] result_q;
    logic [14:0] res_chan_q;

    // No channel shown until a high result read in scan mode
    localparam logic [14:0] RST_CHAN = {adcs_pkg::RST_HIGH,
        adcs_pkg::RST_BYTE};

    assign off_ext = {{6{off_q[7]}}, off_q};
    assign comp = conv_raw - off_ext;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            result_q <= adcs_pkg::RST_RESULT;
            res_chan_q <= RST_CHAN;
        end else if (conv_done) begin
            result_q <= comp;
            res_chan_q <= adcs_pkg::ONE_HOT_BASE << ptr_q;
        end
    end

    // High byte read freezes low byte, and channel in scan mode
    logic rd_res_high;
    logic [7:0] low_shadow_q;
    logic [14:0] shown_chan_q;

    assign rd_res_high = rd_acc && addr_ok &&
        (addr_idx == adcs_pkg::IDX_RES_HIGH);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            low_shadow_q <= adcs_pkg::RST_BYTE;
            shown_chan_q <= RST_CHAN;
        end else if (rd_res_high) begin
            low_shadow_q <= result_q[7:0];
            if (scan_q) begin
                shown_chan_q <= res_chan_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data

    logic [7:0] rd_byte;

    always_comb begin
        rd_byte = adcs_pkg::RST_BYTE;
        if (!addr_ok) begin
            rd_byte = adcs_pkg::RST_BYTE;
        end else if (addr_idx == adcs_pkg::IDX_SEL_HIGH) begin
            if (scan_q) begin
                rd_byte = {1'b0, shown_chan_q[14:8]};
            end else begin
                rd_byte = {1'b0, sel_high_d};
            end
        end else if (addr_idx == adcs_pkg::IDX_SEL_LOW) begin
            if (scan_q) begin
                rd_byte = shown_chan_q[7:0];
            end else begin
                rd_byte = sel_low_d;
            end
        end else if (addr_idx == adcs_pkg::IDX_OFFSET) begin
            rd_byte = off_d;
        end else if (addr_idx == adcs_pkg::IDX_RES_HIGH) begin
            rd_byte = {2'b00, result_q[13:8]};
        end else if (addr_idx == adcs_pkg::IDX_RES_LOW) begin
            rd_byte = low_shadow_q;
        end else if (addr_idx == adcs_pkg::IDX_CTRL) begin
            rd_byte = {6'h00, pair_d, scan_d};
        end
    end

    // Taken in the address phase, stands through the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= adcs_pkg::RST_WORD;
        end else if (rd_acc) begin
            hrdata <= {24'h00_0000, rd_byte};
        end
    end

endmodule

// ===== common/adcs_pkg.sv
package adcs_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register indices, byte address is four times the index
    localparam logic [11:0] IDX_SEL_HIGH = 12'h0f73;
    localparam logic [11:0] IDX_SEL_LOW = 12'h0f74;
    localparam logic [11:0] IDX_OFFSET = 12'h0f75;
    localparam logic [11:0] IDX_RES_HIGH = 12'h0f76;
    localparam logic [11:0] IDX_RES_LOW = 12'h0f77;
    localparam logic [11:0] IDX_CTRL = 12'h0f7f;

    // Index field of haddr and the bits above it
    localparam int IDX_LSB = 2;
    localparam int IDX_MSB = 13;
    localparam logic [17:0] ADDR_HIGH_ZERO = 18'h0_0000;

    ////////////////////////////////////////////////////////////////////////
    // Control register fields
    localparam int CTRL_SCAN_BIT = 0;
    localparam int CTRL_PAIR_BIT = 1;

    // Reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [6:0] RST_HIGH = 7'h00;
    localparam logic [13:0] RST_RESULT = 14'h0000;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////
    // Channel map
    localparam int NUM_CH = 15;
    localparam int NUM_PAIRS = 6;
    localparam logic [3:0] CH_AMP0 = 4'hd;
    localparam logic [3:0] CH_AMP1 = 4'he;
    localparam logic [3:0] CH_FIRST = 4'h0;
    localparam logic [4:0] CODE_AMP0 = 5'h0f;
    localparam logic [4:0] CODE_AMP1 = 5'h10;
    localparam logic [14:0] ONE_HOT_BASE = 15'h0001;

    // AHB constants
    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
    localparam logic HRESP_OKAY = 1'b0;

    // Source selection for the converter front end
    typedef struct packed {
        logic diff;
        logic [4:0] pos;
        logic [3:0] neg;
    } adcs_mux_t;

    localparam adcs_mux_t MUX_RESET = '{diff: 1'b0, pos: 5'h00, neg: 4'h0};

endpackage

// ===== core/adcs_scan_next.sv
`timescale 1ns/100ps
module adcs_scan_next (
    input wire logic [14:0] set_vec,
    input wire logic [3:0] cur,
    output logic [3:0] nxt
);

    // Lowest set channel above cur, else lowest set channel overall
    always_comb begin
        nxt = cur;
        for (int i = adcs_pkg::NUM_CH - 1; i >= 0; i--) begin
            if (set_vec[i]) begin
                nxt = 4'(i);
            end
        end
        for (int i = adcs_pkg::NUM_CH - 1; i >= 0; i--) begin
            if (set_vec[i] && (4'(i) > cur)) begin
                nxt = 4'(i);
            end
        end
    end

endmodule

// ===== verification/adcs_chk.sv
`timescale 1ns/100ps
module adcs_chk (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic cal_done,
    input wire logic [7:0] cal_value,
    input wire adcs_pkg::adcs_mux_t mux_sel,
    input wire logic [7:0] offset_value,
    input wire logic scan_mode
);
    localparam logic [31:0] OFF_A = {adcs_pkg::ADDR_HIGH_ZERO,
        adcs_pkg::IDX_OFFSET, 2'b00};
    localparam logic [31:0] CTL_A = {adcs_pkg::ADDR_HIGH_ZERO,
        adcs_pkg::IDX_CTRL, 2'b00};
    wire logic req = hsel && hready && htrans == adcs_pkg::HTRANS_NONSEQ;
    wire logic [7:0] wlow = hwdata[7:0];
    wire logic wscan = hwdata[adcs_pkg::CTRL_SCAN_BIT];
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_ready_high: assert property (hreadyout)
        else $error("hreadyout went low");
    a_resp_okay: assert property (hresp == adcs_pkg::HRESP_OKAY)
        else $error("hresp not okay");
    a_rdata_upper: assert property (hrdata[31:8] == 24'h00_0000)
        else $error("hrdata upper bits set");
    a_rdata_hold: assert property (!(req && !hwrite) |=> $stable(hrdata))
        else $error("hrdata changed without a read");
    a_off_write: assert property (req && hwrite && haddr == OFF_A
        ##1 !cal_done |=> offset_value == $past(wlow))
        else $error("offset write not applied");
    a_cal_load: assert property (cal_done
        |=> offset_value == $past(cal_value))
        else $error("calibration value not loaded");
    a_scan_copy: assert property (req && hwrite && haddr == CTL_A
        ##1 1'b1 |-> ##2 scan_mode == $past(wscan, 2))
        else $error("scan mode not following control");
    a_diff_pair: assert property (mux_sel.diff
        |-> !mux_sel.pos[0] && mux_sel.neg == mux_sel.pos[3:0] + 4'h1)
        else $error("differential pair mismatch");
    a_reset_vals: assert property ($rose(hresetn)
        |-> offset_value == adcs_pkg::RST_BYTE && !scan_mode
        && mux_sel == adcs_pkg::MUX_RESET)
        else $error("bad values after reset");
endmodule

bind adcs_input_regs adcs_chk u_chk (.hclk, .hresetn, .hsel, .haddr,
    .htrans, .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp,
    .cal_done, .cal_value, .mux_sel, .offset_value, .scan_mode);

// ===== verification/tb_top.sv
`timescale 1ns/100ps
module tb_top;
    localparam logic [11:0] SL = adcs_pkg::IDX_SEL_LOW;
    localparam logic [11:0] SH = adcs_pkg::IDX_SEL_HIGH;
    localparam logic [11:0] OF = adcs_pkg::IDX_OFFSET;
    localparam logic [11:0] RH = adcs_pkg::IDX_RES_HIGH;
    localparam logic [11:0] RL = adcs_pkg::IDX_RES_LOW;
    localparam logic [11:0] CT = adcs_pkg::IDX_CTRL;
    typedef struct packed {
        logic [11:0] i;
        logic [31:0] d;
        logic [31:0] e;
    } adcs_row_t;
    adcs_row_t rows [5] = '{'{SL, 32'h0000_0011, 32'h0000_0011},
        '{SH, 32'hffff_ffff, 32'h0000_007f},
        '{OF, 32'h0000_01a5, 32'h0000_00a5},
        '{RH, 32'h0000_00ff, 32'h0}, '{12'hf70, 32'h0000_00ff, 32'h0}};
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hready;
    logic conv_done = 0, cal_done = 0, hreadyout, hresp, scan_mode;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, r;
    logic [1:0] htrans = '0;
    logic [2:0] hsize = 3'h2;
    logic [13:0] conv_raw = '0;
    logic [7:0] cal_value = '0, offset_value;
    logic [14:0] ids [3];
    adcs_pkg::adcs_mux_t mux_sel;
    int err_count = 0, compares = 0;
    assign hready = hreadyout;
    always #10 hclk = ~hclk;

    adcs_input_regs DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
        .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .conv_done,
        .conv_raw, .cal_done, .cal_value, .mux_sel, .offset_value,
        .scan_mode);

    ////////////////////////////////////////////////////////////////////////
    task chk_bus(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    task chk_sig(input string n, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    task stop_test;
        $display("mismatches %0d of %0d compares", err_count, compares);
        if (err_count == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task bus(input logic w, input logic [11:0] i, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= adcs_pkg::HTRANS_NONSEQ;
        haddr <= {adcs_pkg::ADDR_HIGH_ZERO, i, 2'b00};
        hwrite <= w;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        r = hrdata;
    endtask
    task rd_chk(input logic [11:0] i, input logic [31:0] e);
        bus(1'b0, i, '0);
        chk_bus("hrdata", e, r);
    endtask
    task settle;
        repeat (3) @(posedge hclk);
        #1;
    endtask
    task conv(input logic [13:0] raw);
        @(posedge hclk);
        conv_done <= 1'b1;
        conv_raw <= raw;
        @(posedge hclk);
        conv_done <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge hclk);
        err_count++;
        stop_test;
    end
    initial begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        for (int k = 0; k < 5; k++) begin
            bus(1'b1, rows[k].i, rows[k].d);
            rd_chk(rows[k].i, rows[k].e);
        end
        chk_sig("offset_value", 8'ha5, offset_value);
        bus(1'b1, CT, '0);
        for (int c = 0; c < 19; c++) begin
            bus(1'b1, SL, 32'(c));
            settle;
            chk_sig("mux_pos", 8'(c), {3'b0, mux_sel.pos});
            chk_sig("mux_diff", 8'h0, {7'b0, mux_sel.diff});
        end
        bus(1'b1, CT, 32'h2);
        for (int n = 0; n < 6; n++) begin
            bus(1'b1, SL, 32'(2 * n + 1));
            settle;
            chk_sig("mux_pos", 8'(2 * n), {3'b0, mux_sel.pos});
            chk_sig("mux_neg", 8'(2 * n + 1), {4'b0, mux_sel.neg});
        end
        bus(1'b1, CT, '0);
        bus(1'b1, OF, 32'h0000_00fe);
        conv(14'h1234);
        rd_chk(RH, 32'h12);
        rd_chk(RL, 32'h36);
        conv(14'h0000);
        rd_chk(RL, 32'h36);
        rd_chk(RH, 32'h0);
        rd_chk(RL, 32'h2);
        @(posedge hclk);
        cal_done <= 1'b1;
        cal_value <= 8'h81;
        @(posedge hclk);
        cal_done <= 1'b0;
        rd_chk(OF, 32'h81);
        bus(1'b1, SL, 32'h4);
        bus(1'b1, SH, 32'h20);
        bus(1'b1, CT, 32'h1);
        for (int s = 0; s < 3; s++) begin
            conv(14'h0100);
            bus(1'b0, RH, '0);
            bus(1'b0, SH, '0);
            ids[s][14:8] = r[6:0];
            bus(1'b0, SL, '0);
            ids[s][7:0] = r[7:0];
        end
        chk_bus("scan_first", 32'h1,
            32'((ids[0] == 15'h4) || (ids[0] == 15'h2000)));
        chk_bus("scan_next", {17'h0, ids[0] ^ 15'h2004}, {17'h0, ids[1]});
        chk_bus("scan_wrap", {17'h0, ids[0]}, {17'h0, ids[2]});
        settle;
        chk_sig("mux_amp0", 8'h0f, {3'b0, mux_sel.pos});
        bus(1'b1, SL, 32'h22);
        bus(1'b1, CT, 32'h3);
        settle;
        chk_sig("scan_mode", 8'h1, {7'b0, scan_mode});
        chk_sig("mux_pos", 8'h2, {3'b0, mux_sel.pos});
        chk_sig("mux_neg", 8'h3, {4'b0, mux_sel.neg});
        chk_sig("mux_diff", 8'h1, {7'b0, mux_sel.diff});
        conv(14'h0100);
        bus(1'b0, RH, '0);
        rd_chk(SL, 32'h2);
        chk_sig("mux_pos", 8'ha, {3'b0, mux_sel.pos});
        chk_sig("mux_neg", 8'hb, {4'b0, mux_sel.neg});
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        rd_chk(OF, '0);
        rd_chk(SL, '0);
        chk_sig("scan_mode", 8'h0, {7'b0, scan_mode});
        stop_test;
    end
endmodule
